// ### rtl/power_regs_pkg.sv
// Constants for the page, status and shutdown-cause register bank.
// Assumes a single 100 MHz clock and a two-wire serial host on SCL/SDA.
package power_regs_pkg;

   // ****************************************
   // Address map
   // ****************************************
   localparam int               ADDR_W             = 13;
   localparam int               PAGE_W             = 6;
   localparam int               REG_W              = 8;
   localparam int               LOW_ADDR_W         = 7;
   localparam logic [12:0]      ADDR_PAGE_CTRL     = 13'h000;
   localparam logic [12:0]      ADDR_RAMP_KEY      = 13'h001;
   localparam logic [12:0]      ADDR_PIN_LEVELS    = 13'h002;
   localparam logic [12:0]      ADDR_LDO_OC        = 13'h004;
   localparam logic [12:0]      ADDR_SHUTDOWN_LOG  = 13'h005;

   // ****************************************
   // Field layout
   // ****************************************
   localparam int               PC_AUTO_RETURN_BIT = 7;
   localparam int               PC_WRITE_MODE_BIT  = 6;
   localparam int               PC_PAGE_MSB        = 5;
   localparam int               RK_RAMP_BIT        = 2;
   localparam int               RK_KEY_BIT         = 0;
   localparam int               FL_WAIT_BIT        = 7;
   localparam int               FL_RESET_REQ_BIT   = 6;
   localparam int               FL_BUTTON_BIT      = 5;
   localparam int               FL_OVERHEAT_BIT    = 4;
   localparam int               FL_UV_START_BIT    = 3;
   localparam int               FL_UV_BIT          = 2;
   localparam int               FL_COLD_START_BIT  = 1;
   localparam int               FL_WATCHDOG_BIT    = 0;
   localparam int               GPI_N              = 5;
   localparam int               LDO_N              = 4;

   // ****************************************
   // Reset values and encodings
   // ****************************************
   localparam logic [7:0]       PAGE_CTRL_RESET    = 8'h00;
   localparam logic [7:0]       LOG_RESET          = 8'h00;
   localparam logic [7:0]       UNMAPPED_READ      = 8'h00;
   localparam logic [5:0]       PAGE_ZERO          = 6'h00;
   localparam logic             WRITE_MODE_SEQ     = 1'b0;
   localparam logic             AUTO_RETURN_ON     = 1'b1;
   localparam logic [3:0]       BYTE_BITS          = 4'h8;
   localparam logic [3:0]       BIT_FIRST          = 4'h1;
   // Arbitrary serial device address
   localparam logic [6:0]       DEV_ADDR_DEF       = 7'h2C;

   // ****************************************
   // Timing
   // ****************************************
   localparam longint           CLK_HZ             = 64'd100000000;
   localparam longint           START_WINDOW_S     = 64'd16;
   localparam longint           START_WINDOW_CYC   = START_WINDOW_S * CLK_HZ;
   localparam int               WINDOW_W           = 31;

   typedef enum logic [9:0] {
      SER_IDLE     = 10'b00_0000_0001,
      SER_DEV      = 10'b00_0000_0010,
      SER_DEV_ACK  = 10'b00_0000_0100,
      SER_REG      = 10'b00_0000_1000,
      SER_REG_ACK  = 10'b00_0001_0000,
      SER_WR       = 10'b00_0010_0000,
      SER_WR_ACK   = 10'b00_0100_0000,
      SER_RD       = 10'b00_1000_0000,
      SER_RD_ACK   = 10'b01_0000_0000,
      SER_RD_NEXT  = 10'b10_0000_0000
   } ser_state_e;

endpackage

// ### rtl/sync_2ff.sv
// Two-stage synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no bus coherence is given.
`timescale 1ns/100ps
module sync_2ff #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_b,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;
endmodule // sync_2ff

// ### rtl/sticky_flag.sv
// One sticky flag, set by hardware, cleared by a host write of one.
// Assumes only the power-on reset clears it otherwise.
`timescale 1ns/100ps
module sticky_flag (
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_set,
   input  wire logic i_clr,
   output logic      o_flag
);
   logic flag_reg;
   logic flag_next;

   always_comb begin
      flag_next = i_set | (flag_reg & ~i_clr);
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign o_flag = flag_reg;
endmodule // sticky_flag

// ### rtl/page_status_fault_regs.sv
// Page control, status and shutdown-cause registers on a two-wire slave.
// Assumes cause pulses come from same-clock sequencer logic; pins are async.
`timescale 1ns/100ps
module page_status_fault_regs
   import power_regs_pkg::*;
#(
   parameter int                    NUM_RAMP_SUPPLIES = 3,
   parameter logic [6:0]            DEV_ADDR          = DEV_ADDR_DEF,
   parameter logic [WINDOW_W-1:0]   START_WINDOW      = WINDOW_W'(START_WINDOW_CYC)
) (
   input  wire logic                         I_MCLK,
   input  wire logic                         I_RST_B,
   input  wire logic                         I_SCL,
   input  wire logic                         I_SDA,
   output logic                              O_SDA,
   output logic                              O_SDA_OE,
   input  wire logic [NUM_RAMP_SUPPLIES-1:0] I_VOLTAGE_RAMP_ACTIVE,
   input  wire logic                         I_POWER_BUTTON_INPUT,
   input  wire logic [GPI_N-1:0]             I_GPI_LEVEL,
   input  wire logic [LDO_N-1:0]             I_LDO_OVERCURRENT,
   input  wire logic                         I_WAIT_TIMEOUT_OFF,
   input  wire logic                         I_RESET_REQUEST_OFF,
   input  wire logic                         I_POWER_BUTTON_OFF,
   input  wire logic                         I_OVERHEAT_OFF,
   input  wire logic                         I_MAIN_SUPPLY_RAIL_UV_OFF,
   input  wire logic                         I_WATCHDOG_EXPIRY_FLAG,
   input  wire logic                         I_SYSTEM_RESET_OUTPUT_RELEASED,
   output logic [PAGE_W-1:0]                 O_PAGE_SEL,
   output logic                              O_WRITE_MODE,
   output logic                              O_PAGE_AUTO_RETURN
);

   // ****************************************
   // Parameter checks
   // ****************************************
   if (NUM_RAMP_SUPPLIES < 1) begin : g_chk_ramp
      $error("NUM_RAMP_SUPPLIES must be at least 1");
   end
   if (START_WINDOW == '0) begin : g_chk_window
      $error("START_WINDOW must be nonzero");
   end

   localparam int SYNC_W = 2 + NUM_RAMP_SUPPLIES + 1 + GPI_N + LDO_N;

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [SYNC_W-1:0]            sync_out;
   logic                         scl_s;
   logic                         sda_s;
   logic [NUM_RAMP_SUPPLIES-1:0] ramp_s;
   logic                         button_s;
   logic [GPI_N-1:0]             gpi_s;
   logic [LDO_N-1:0]             ldo_s;

   sync_2ff #(
      .W       (SYNC_W)
   ) u_sync (
      .i_clk   (I_MCLK),
      .i_rst_b (I_RST_B),
      .i_async ({~I_SCL, ~I_SDA, I_VOLTAGE_RAMP_ACTIVE, I_POWER_BUTTON_INPUT,
                 I_GPI_LEVEL, I_LDO_OVERCURRENT}),
      .o_sync  (sync_out)
   );

   // Bus pins pass inverted so reset reads them idle high
   assign {scl_s, sda_s, ramp_s, button_s, gpi_s, ldo_s} =
      {~sync_out[SYNC_W-1 -: 2], sync_out[SYNC_W-3:0]};

   // ****************************************
   // Bus edge detection
   // ****************************************
   logic scl_d_reg;
   logic sda_d_reg;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_d_reg;
   assign scl_fall  = ~scl_s & scl_d_reg;
   assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // ****************************************
   // Register state and read mux
   // ****************************************
   logic [7:0]        page_ctrl_reg;
   logic [7:0]        page_ctrl_next;
   logic [7:0]        log_q;
   logic [ADDR_W-1:0] full_addr;
   logic [7:0]        ptr_reg;
   logic [7:0]        rd_data;

   assign full_addr = {page_ctrl_reg[PC_PAGE_MSB:1], ptr_reg};

   always_comb begin
      rd_data = UNMAPPED_READ;
      if (full_addr[LOW_ADDR_W-1:0] == ADDR_PAGE_CTRL[LOW_ADDR_W-1:0]) begin
         rd_data = page_ctrl_reg;
      end else begin
         unique case (full_addr)
            ADDR_RAMP_KEY: begin
               rd_data[RK_RAMP_BIT] = |ramp_s;
               rd_data[RK_KEY_BIT]  = button_s;
            end
            ADDR_PIN_LEVELS: begin
               rd_data[GPI_N-1:0] = gpi_s;
            end
            ADDR_LDO_OC: begin
               rd_data[LDO_N-1:0] = ldo_s;
            end
            ADDR_SHUTDOWN_LOG: begin
               rd_data = log_q;
            end
            default: begin
               rd_data = UNMAPPED_READ;
            end
         endcase
      end
   end

   // ****************************************
   // Two-wire slave
   // ****************************************
   ser_state_e st_reg;
   ser_state_e st_next;
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic [7:0] sh_reg;
   logic [7:0] sh_next;
   logic [7:0] ptr_next;
   logic       oe_reg;
   logic       oe_next;
   logic       wr_en;
   logic       rd_en;

   always_comb begin
      st_next  = st_reg;
      cnt_next = cnt_reg;
      sh_next  = sh_reg;
      ptr_next = ptr_reg;
      oe_next  = oe_reg;
      wr_en    = 1'b0;
      rd_en    = 1'b0;
      if (bus_start) begin
         st_next  = SER_DEV;
         cnt_next = '0;
         oe_next  = 1'b0;
      end else if (bus_stop) begin
         st_next = SER_IDLE;
         oe_next = 1'b0;
      end else begin
         unique case (st_reg)
            SER_IDLE: begin
               oe_next = 1'b0;
            end
            SER_DEV, SER_REG, SER_WR: begin
               if (scl_rise && cnt_reg != BYTE_BITS) begin
                  sh_next  = {sh_reg[6:0], sda_s};
                  cnt_next = cnt_reg + BIT_FIRST;
               end else if (scl_fall && cnt_reg == BYTE_BITS) begin
                  oe_next = 1'b1;
                  if (st_reg == SER_DEV) begin
                     if (sh_reg[7:1] == DEV_ADDR) begin
                        st_next = SER_DEV_ACK;
                     end else begin
                        st_next = SER_IDLE;
                        oe_next = 1'b0;
                     end
                  end else if (st_reg == SER_REG) begin
                     ptr_next = sh_reg;
                     st_next  = SER_REG_ACK;
                  end else begin
                     wr_en   = 1'b1;
                     st_next = SER_WR_ACK;
                     if (page_ctrl_reg[PC_WRITE_MODE_BIT] == WRITE_MODE_SEQ) begin
                        ptr_next = ptr_reg + 8'h01;
                     end
                  end
               end
            end
            SER_DEV_ACK: begin
               if (scl_fall) begin
                  cnt_next = '0;
                  oe_next  = 1'b0;
                  st_next  = SER_REG;
                  if (sh_reg[0]) begin
                     rd_en    = 1'b1;
                     sh_next  = {rd_data[6:0], 1'b0};
                     oe_next  = ~rd_data[7];
                     cnt_next = BIT_FIRST;
                     ptr_next = ptr_reg + 8'h01;
                     st_next  = SER_RD;
                  end
               end
            end
            SER_REG_ACK: begin
               if (scl_fall) begin
                  cnt_next = '0;
                  oe_next  = 1'b0;
                  st_next  = SER_WR;
               end
            end
            SER_WR_ACK: begin
               if (scl_fall) begin
                  cnt_next = '0;
                  oe_next  = 1'b0;
                  st_next  = (page_ctrl_reg[PC_WRITE_MODE_BIT] == WRITE_MODE_SEQ)
                             ? SER_WR : SER_REG;
               end
            end
            SER_RD: begin
               if (scl_fall) begin
                  if (cnt_reg == BYTE_BITS) begin
                     oe_next = 1'b0;
                     st_next = SER_RD_ACK;
                  end else begin
                     oe_next  = ~sh_reg[7];
                     sh_next  = {sh_reg[6:0], 1'b0};
                     cnt_next = cnt_reg + BIT_FIRST;
                  end
               end
            end
            SER_RD_ACK: begin
               if (scl_rise) begin
                  st_next = sda_s ? SER_IDLE : SER_RD_NEXT;
               end
            end
            SER_RD_NEXT: begin
               if (scl_fall) begin
                  rd_en    = 1'b1;
                  sh_next  = {rd_data[6:0], 1'b0};
                  oe_next  = ~rd_data[7];
                  cnt_next = BIT_FIRST;
                  ptr_next = ptr_reg + 8'h01;
                  st_next  = SER_RD;
               end
            end
         endcase
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         st_reg  <= SER_IDLE;
         cnt_reg <= '0;
         sh_reg  <= '0;
         ptr_reg <= '0;
         oe_reg  <= 1'b0;
      end else begin
         st_reg  <= st_next;
         cnt_reg <= cnt_next;
         sh_reg  <= sh_next;
         ptr_reg <= ptr_next;
         oe_reg  <= oe_next;
      end
   end

   // ****************************************
   // Page control
   // ****************************************
   logic hit_page_ctrl;
   logic hit_log;

   assign hit_page_ctrl = (full_addr[LOW_ADDR_W-1:0] == ADDR_PAGE_CTRL[LOW_ADDR_W-1:0]);
   assign hit_log       = (full_addr == ADDR_SHUTDOWN_LOG);

   always_comb begin
      page_ctrl_next = page_ctrl_reg;
      if (wr_en && hit_page_ctrl) begin
         page_ctrl_next = sh_reg;
      end else if ((wr_en || rd_en) &&
                   page_ctrl_reg[PC_AUTO_RETURN_BIT] == AUTO_RETURN_ON) begin
         page_ctrl_next[PC_PAGE_MSB:0] = PAGE_ZERO;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         page_ctrl_reg <= PAGE_CTRL_RESET;
      end else begin
         page_ctrl_reg <= page_ctrl_next;
      end
   end

   // ****************************************
   // Start-up under-voltage window
   // ****************************************
   logic [WINDOW_W-1:0] win_reg;
   logic [WINDOW_W-1:0] win_next;
   logic                rel_d_reg;
   logic                cold_reg;
   logic                in_window;

   always_comb begin
      win_next = win_reg;
      if (I_SYSTEM_RESET_OUTPUT_RELEASED && !rel_d_reg) begin
         win_next = START_WINDOW;
      end else if (win_reg != '0) begin
         win_next = win_reg - WINDOW_W'(1);
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         win_reg   <= '0;
         rel_d_reg <= 1'b0;
         cold_reg  <= 1'b1;
      end else begin
         win_reg   <= win_next;
         rel_d_reg <= I_SYSTEM_RESET_OUTPUT_RELEASED;
         cold_reg  <= 1'b0;
      end
   end

   assign in_window = ~I_SYSTEM_RESET_OUTPUT_RELEASED | (win_reg != '0);

   // ****************************************
   // Shutdown cause log
   // ****************************************
   logic [7:0] log_set;
   logic [7:0] log_clr;

   always_comb begin
      log_set                    = LOG_RESET;
      log_set[FL_WAIT_BIT]       = I_WAIT_TIMEOUT_OFF;
      log_set[FL_RESET_REQ_BIT]  = I_RESET_REQUEST_OFF;
      log_set[FL_BUTTON_BIT]     = I_POWER_BUTTON_OFF;
      log_set[FL_OVERHEAT_BIT]   = I_OVERHEAT_OFF;
      log_set[FL_UV_START_BIT]   = I_MAIN_SUPPLY_RAIL_UV_OFF & in_window;
      log_set[FL_UV_BIT]         = I_MAIN_SUPPLY_RAIL_UV_OFF;
      log_set[FL_COLD_START_BIT] = cold_reg;
      log_set[FL_WATCHDOG_BIT]   = I_WATCHDOG_EXPIRY_FLAG;
      log_clr                    = (wr_en && hit_log) ? sh_reg : LOG_RESET;
   end

   for (genvar b = 0; b < REG_W; b++) begin : g_log
      sticky_flag u_flag (
         .i_clk   (I_MCLK),
         .i_rst_b (I_RST_B),
         .i_set   (log_set[b]),
         .i_clr   (log_clr[b]),
         .o_flag  (log_q[b])
      );
   end

   // ****************************************
   // Outputs
   // ****************************************
   logic sda_low_reg;

   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         sda_low_reg <= 1'b0;
      end else begin
         sda_low_reg <= 1'b0;
      end
   end

   assign O_SDA              = sda_low_reg;
   assign O_SDA_OE           = oe_reg;
   assign O_PAGE_SEL         = page_ctrl_reg[PC_PAGE_MSB:0];
   assign O_WRITE_MODE       = page_ctrl_reg[PC_WRITE_MODE_BIT];
   assign O_PAGE_AUTO_RETURN = page_ctrl_reg[PC_AUTO_RETURN_BIT];

endmodule // page_status_fault_regs

// ### testbench/page_status_fault_regs_assertions.sv
// Port checker for the page and shutdown-cause register bank.
// Bound to page_status_fault_regs; sees its ports only.
`timescale 1ns/100ps
module page_regs_checker
   import power_regs_pkg::*;
(
   input wire logic              I_MCLK,
   input wire logic              I_RST_B,
   input wire logic              I_SCL,
   input wire logic              O_SDA,
   input wire logic              O_SDA_OE,
   input wire logic [PAGE_W-1:0] O_PAGE_SEL,
   input wire logic              O_WRITE_MODE,
   input wire logic              O_PAGE_AUTO_RETURN
);
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_B);

   reset_values_a:
      assert property ($rose(I_RST_B) |-> O_PAGE_SEL == 6'h00 && !O_WRITE_MODE)
      else $error("page control not clear after reset");
   open_drain_a:
      assert property (O_SDA_OE |-> O_SDA == 1'b0)
      else $error("data output not low while driving");
   ack_rise_a:
      assert property ($rose(O_SDA_OE) |-> !I_SCL)
      else $error("data enable rose with clock high");
   ack_release_a:
      assert property ($fell(O_SDA_OE) |-> !I_SCL)
      else $error("data enable fell with clock high");
   bit_hold_a:
      assert property ($rose(O_SDA_OE) |-> O_SDA_OE [*4])
      else $error("data enable too short");
   page_write_a:
      assert property ($changed(O_PAGE_SEL) && !$past(O_PAGE_AUTO_RETURN)
                       |-> ##[0:4] O_SDA_OE)
      else $error("page moved without a write");
   mode_write_a:
      assert property ($changed(O_WRITE_MODE) |-> ##[0:4] O_SDA_OE)
      else $error("write style moved without a write");
   page_auto_return_write_a:
      assert property ($changed(O_PAGE_AUTO_RETURN) |-> ##[0:4] O_SDA_OE)
      else $error("page_auto_return bit moved without a write");
   page_clock_low_a:
      assert property ($changed(O_PAGE_SEL) |-> !I_SCL)
      else $error("page moved with clock high");
endmodule // page_regs_checker

bind page_status_fault_regs page_regs_checker u_checker (
   .I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_SCL(I_SCL), .O_SDA(O_SDA),
   .O_SDA_OE(O_SDA_OE), .O_PAGE_SEL(O_PAGE_SEL), .O_WRITE_MODE(O_WRITE_MODE),
   .O_PAGE_AUTO_RETURN(O_PAGE_AUTO_RETURN));

// ### testbench/serial_host.sv
// Two-wire host model: SCL and an open-drain SDA with pull-up.
// Assumes the device pulls SDA low while its enable is high.
`timescale 1ns/100ps
module serial_host #(
   parameter logic [6:0] DEV = 7'h2C
) (
   input  wire logic i_clk,
   input  wire logic i_dev_oe,
   input  wire logic i_dev_sda,
   output logic      o_scl,
   output logic      o_sda
);
   logic sda_drv = 1'b1;
   initial o_scl = 1'b1;
   // Pull-up unless the device drives its output value
   assign o_sda = sda_drv & (~i_dev_oe | i_dev_sda);

   task automatic step(input logic c, input logic b);
      o_scl = c;
      sda_drv = b;
      repeat (4) @(negedge i_clk);
   endtask

   task automatic start;
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask

   // Byte plus acknowledge bit
   task automatic xfer(input logic [8:0] t, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         step(1'b0, t[i]);
         step(1'b1, t[i]);
         r[i] = o_sda;
         step(1'b1, t[i]);
         step(1'b0, t[i]);
      end
   endtask

   task automatic wr(input logic [7:0] b[$], output logic nak);
      logic [8:0] r;
      start;
      xfer({DEV, 2'b01}, r);
      nak = r[0];
      foreach (b[k]) begin
         xfer({b[k], 1'b1}, r);
         nak |= r[0];
      end
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask

   // Second byte only when two is set; master acknowledges the first only then
   task automatic rd(input logic [7:0] p, input logic two, output logic [7:0] d,
                     output logic [7:0] d2, output logic nak);
      logic [8:0] r;
      start;
      xfer({DEV, 2'b01}, r);
      nak = r[0];
      xfer({p, 1'b1}, r);
      nak |= r[0];
      start;
      xfer({DEV, 2'b11}, r);
      nak |= r[0];
      xfer({8'hFF, ~two}, r);
      d = r[8:1];
      d2 = 8'h00;
      if (two) begin
         xfer(9'h1FF, r);
         d2 = r[8:1];
      end
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
endmodule // serial_host

// ### testbench/testbench.sv
// Self-checking bench for the page and shutdown-cause registers.
// Assumes serial_host as bus master and the bound checker.
`timescale 1ns/100ps
module testbench;
   import power_regs_pkg::*;
   localparam int SW = 50;
   logic       clk   = 1'b0;
   logic       rst_b = 1'b0;
   logic [2:0] ramp  = 3'h0;
   logic       btn   = 1'b0;
   logic [4:0] gpi   = 5'h00;
   logic [3:0] ldo   = 4'h0;
   logic [5:0] cause = 6'h00;
   logic       rel   = 1'b0;
   logic       scl;
   logic       sda;
   logic       oe;
   logic       sda_o;
   logic       arev;
   logic [7:0] d2;
   logic       wmode;
   logic       nak;
   logic [5:0] page;
   logic [7:0] d;
   logic [7:0] v;
   logic [7:0] s     = 8'h46;
   int         fail_count = 0;
   int         n_compared = 0;

   always #5 clk = ~clk;

   serial_host u_host (.i_clk(clk), .i_dev_oe(oe), .i_dev_sda(sda_o), .o_scl(scl),
                       .o_sda(sda));

   page_status_fault_regs #(.START_WINDOW(WINDOW_W'(SW))) dut (
      .I_MCLK(clk), .I_RST_B(rst_b), .I_SCL(scl), .I_SDA(sda), .O_SDA(sda_o),
      .O_SDA_OE(oe), .I_VOLTAGE_RAMP_ACTIVE(ramp), .I_POWER_BUTTON_INPUT(btn),
      .I_GPI_LEVEL(gpi), .I_LDO_OVERCURRENT(ldo), .I_WAIT_TIMEOUT_OFF(cause[0]),
      .I_RESET_REQUEST_OFF(cause[1]), .I_POWER_BUTTON_OFF(cause[2]),
      .I_OVERHEAT_OFF(cause[3]), .I_WATCHDOG_EXPIRY_FLAG(cause[4]),
      .I_MAIN_SUPPLY_RAIL_UV_OFF(cause[5]), .I_SYSTEM_RESET_OUTPUT_RELEASED(rel),
      .O_PAGE_SEL(page), .O_WRITE_MODE(wmode), .O_PAGE_AUTO_RETURN(arev));

   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction

   function automatic logic [7:0] log_bits(input int k);
      logic [7:0] t [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h01, 8'h0C};
      return t[k];
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] p, input logic [7:0] exp);
      u_host.rd(p, 1'b0, d, d2, nak);
      chk({7'h0, nak}, 8'h00); // bytes acknowledged
      chk(d, exp); // addressed read data
   endtask

   task automatic wr(input logic [7:0] b[$]);
      u_host.wr(b, nak);
      chk({7'h0, nak}, 8'h00); // bytes acknowledged
   endtask

   task automatic pulse(input logic [5:0] m);
      @(negedge clk);
      cause = m;
      @(negedge clk);
      cause = 6'h00;
   endtask

   task automatic hit(input int k, input logic [7:0] exp);
      pulse(6'h01 << k);
      rdchk(8'h05, exp); // flag held after pulse
      wr('{8'h05, exp});
      rdchk(8'h05, 8'h00); // written back clears
   endtask

   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      rdchk(8'h05, 8'h02); // cold start
      wr('{8'h05, 8'h02});
      for (int k = 0; k < 6; k++) begin
         hit(k, log_bits(k)); // each cause
      end
      rel = 1'b1;
      repeat (SW + 10) @(negedge clk);
      hit(5, 8'h04); // late fault
      rel = 1'b0;
      @(negedge clk);
      rel = 1'b1;
      hit(5, 8'h0C); // early fault
      pulse(6'h03);
      wr('{8'h05, 8'h40});
      rdchk(8'h05, 8'h80); // partial clear
      for (int i = 0; i < 4; i++) begin
         s = lfsr(s);
         ramp = (i == 0) ? 3'h0 : s[2:0];
         btn = s[3];
         gpi = s[7:3];
         ldo = s[6:3];
         rdchk(8'h01, {5'h00, |ramp, 1'b0, btn}); // ramp summary
         rdchk(8'h02, {3'h0, gpi}); // input levels
         rdchk(8'h04, {4'h0, ldo}); // overcurrent levels
      end
      u_host.rd(8'h01, 1'b1, d, d2, nak);
      chk({7'h0, nak}, 8'h00); // burst acknowledged
      chk(d, {5'h00, |ramp, 1'b0, btn}); // burst first byte
      chk(d2, {3'h0, gpi}); // burst second byte
      wr('{8'h01, 8'hFF});
      rdchk(8'h01, {5'h00, |ramp, 1'b0, btn}); // write ignored
      rdchk(8'h03, 8'h00); // unmapped read
      for (int i = 0; i < 4; i++) begin
         s = lfsr(s);
         v = (i == 0) ? 8'h41 : (s & 8'h7F);
         wr('{8'h00, v});
         chk({2'h0, page}, {2'h0, v[5:0]}); // page field
         chk({7'h0, wmode}, {7'h0, v[6]}); // write style
         rdchk(8'h80, v); // readback
         rdchk(8'h05, (v[5:1] == 5'h00) ? 8'h80 : 8'h00); // page map
         wr('{8'h00, 8'h00});
      end
      wr('{8'h00, 8'h82});
      chk({2'h0, page}, 8'h02); // page held
      chk({7'h0, arev}, 8'h01); // page_auto_return bit set
      rdchk(8'h05, 8'h00); // page two access
      chk({2'h0, page}, 8'h00); // page reverted
      rdchk(8'h05, 8'h80); // page zero access
      wr('{8'h00, 8'h40});
      chk({7'h0, arev}, 8'h00); // page_auto_return bit cleared
      wr('{8'h05, 8'h80, 8'h00, 8'h00});
      chk({7'h0, wmode}, 8'h00); // pair to control
      rdchk(8'h05, 8'h00); // pair to log
      pulse(6'h01);
      wr('{8'h04, 8'hFF, 8'h80});
      rdchk(8'h05, 8'h00); // sequential bytes
      wr('{8'h00, 8'h3F});
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      chk({2'h0, page}, 8'h00); // page reset
      rdchk(8'h05, 8'h02); // second start
      final_report;
   end

   initial begin
      repeat (90000) @(negedge clk);
      fail_count++;
      final_report;
   end
endmodule // testbench
